// [rtl/pvw_window.sv]
// Address window decode and translation for the second PCI target image
`timescale 1ns/1ps

// Notes on behaviour
// - Block bit acts only A24/A32, width 8-32
// - A24/A32 at 64-bit may use MBLT
// - I/O space forces coupled, ignoring posted bit
// - Width field 23:22, resets to 32-bit
// - Space field 18:16, codes 011/100 reserved
// - Bit 14 selects program or data
// - Bit 12 selects supervisor or user
// - Bit 8 allows single block transfers
// - Bit 0 selects PCI memory or I/O
// - Claim when base <= address < limit
// - Zero limit means no upper bound
// - VME high bits = PCI bits + shift
// - Decode uses only address bits 31:16
module pvw_window (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 pci_req,
    input  wire logic [31:0]          pci_addr,
    input  wire logic                 pci_io,
    output pvw_pkg::pvw_decode_s      decode,
    output logic                      decode_valid
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pvw_pkg::pvw_ctrl_s ctrl_r;
    logic [15:0]        base_r;
    logic [15:0]        limit_r;
    logic [15:0]        shift_r;
    logic [15:0]        hit_count_r;
    pvw_pkg::pvw_apb_e  apb_r;
    logic               wr_fire;
    logic               rd_fire;
    logic               mapped;
    logic [31:0]        rd_word;
    pvw_pkg::pvw_decode_s dec_nxt;

    function automatic logic is_a24_a32(pvw_pkg::pvw_space_e s);
        return (s == pvw_pkg::PVW_A24) || (s == pvw_pkg::PVW_A32);
    endfunction

    function automatic logic [31:0] place_hi(logic [15:0] v);
        return {v, 16'h0000};
    endfunction

    // ------------------------------------------------------------
    // APB handshake: one wait state, answer in access phase
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_r <= pvw_pkg::PVW_ST_IDLE;
        end else begin
            unique case (apb_r)
                pvw_pkg::PVW_ST_IDLE: begin
                    if (psel && !penable) begin
                        apb_r <= pvw_pkg::PVW_ST_ACCESS;
                    end
                end
                pvw_pkg::PVW_ST_ACCESS: begin
                    apb_r <= pvw_pkg::PVW_ST_DONE;
                end
                pvw_pkg::PVW_ST_DONE: begin
                    apb_r <= pvw_pkg::PVW_ST_IDLE;
                end
                default: begin
                    apb_r <= pvw_pkg::PVW_ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        mapped = (paddr == pvw_pkg::OFF_CONTROL) || (paddr == pvw_pkg::OFF_BASE) ||
                 (paddr == pvw_pkg::OFF_LIMIT) || (paddr == pvw_pkg::OFF_SHIFT) ||
                 (paddr == pvw_pkg::OFF_STATUS);
        // Write lands at the edge where the master sees pready
        wr_fire = (apb_r == pvw_pkg::PVW_ST_DONE) && psel && penable && pwrite && mapped;
        rd_fire = (apb_r == pvw_pkg::PVW_ST_ACCESS) && psel && penable && !pwrite;
    end

    // Ready and error raised together, one cycle in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= (apb_r == pvw_pkg::PVW_ST_ACCESS) && psel && penable;
            pslverr <= (apb_r == pvw_pkg::PVW_ST_ACCESS) && psel && penable && !mapped;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r.enable                <= 1'b0;
            ctrl_r.posted                <= 1'b0;
            ctrl_r.width                 <= pvw_pkg::pvw_width_e'(pvw_pkg::RST_WIDTH);
            ctrl_r.space                 <= pvw_pkg::pvw_space_e'(pvw_pkg::RST_SPACE);
            ctrl_r.program_space_flag    <= 1'b0;
            ctrl_r.supervisor            <= 1'b0;
            ctrl_r.block_transfer_select <= 1'b0;
            ctrl_r.pci_space_select      <= 1'b0;
        end else if (wr_fire && paddr == pvw_pkg::OFF_CONTROL) begin
            ctrl_r.enable                <= pwdata[pvw_pkg::BIT_ENABLE];
            ctrl_r.posted                <= pwdata[pvw_pkg::BIT_POSTED];
            ctrl_r.width                 <= pvw_pkg::pvw_width_e'(pwdata[pvw_pkg::WID_HI:pvw_pkg::WID_LO]);
            ctrl_r.space                 <= pvw_pkg::pvw_space_e'(pwdata[pvw_pkg::SPC_HI:pvw_pkg::SPC_LO]);
            ctrl_r.program_space_flag    <= pwdata[pvw_pkg::BIT_PROGRAM];
            ctrl_r.supervisor            <= pwdata[pvw_pkg::BIT_SUPER];
            ctrl_r.block_transfer_select <= pwdata[pvw_pkg::BIT_BLOCK];
            ctrl_r.pci_space_select      <= pwdata[pvw_pkg::BIT_PCI_IO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_r  <= pvw_pkg::RST_ADDR;
            limit_r <= pvw_pkg::RST_ADDR;
            shift_r <= pvw_pkg::RST_ADDR;
        end else if (wr_fire) begin
            if (paddr == pvw_pkg::OFF_BASE) begin
                base_r <= pwdata[pvw_pkg::ADDR_HI:pvw_pkg::ADDR_LO];
            end
            if (paddr == pvw_pkg::OFF_LIMIT) begin
                limit_r <= pwdata[pvw_pkg::ADDR_HI:pvw_pkg::ADDR_LO];
            end
            if (paddr == pvw_pkg::OFF_SHIFT) begin
                shift_r <= pwdata[pvw_pkg::ADDR_HI:pvw_pkg::ADDR_LO];
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        if (paddr == pvw_pkg::OFF_CONTROL) begin
            rd_word[pvw_pkg::BIT_ENABLE]               = ctrl_r.enable;
            rd_word[pvw_pkg::BIT_POSTED]               = ctrl_r.posted;
            rd_word[pvw_pkg::WID_HI:pvw_pkg::WID_LO]   = ctrl_r.width;
            rd_word[pvw_pkg::SPC_HI:pvw_pkg::SPC_LO]   = ctrl_r.space;
            rd_word[pvw_pkg::BIT_PROGRAM]              = ctrl_r.program_space_flag;
            rd_word[pvw_pkg::BIT_SUPER]                = ctrl_r.supervisor;
            rd_word[pvw_pkg::BIT_BLOCK]                = ctrl_r.block_transfer_select;
            rd_word[pvw_pkg::BIT_PCI_IO]               = ctrl_r.pci_space_select;
        end else if (paddr == pvw_pkg::OFF_BASE) begin
            rd_word = place_hi(base_r);
        end else if (paddr == pvw_pkg::OFF_LIMIT) begin
            rd_word = place_hi(limit_r);
        end else if (paddr == pvw_pkg::OFF_SHIFT) begin
            rd_word = place_hi(shift_r);
        end else if (paddr == pvw_pkg::OFF_STATUS) begin
            rd_word = {16'h0000, hit_count_r};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_fire) begin
            prdata <= rd_word;
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Window decode and translation
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] hi;
        logic        above;
        logic        below;
        hi    = pci_addr[pvw_pkg::ADDR_HI:pvw_pkg::ADDR_LO];
        above = hi >= base_r;
        below = (limit_r == pvw_pkg::LIMIT_NONE) || (hi < limit_r);
        dec_nxt.hit = pci_req && ctrl_r.enable && above && below &&
                      (pci_io == ctrl_r.pci_space_select);
        dec_nxt.vme_addr = {16'(hi + shift_r), pci_addr[pvw_pkg::ADDR_LO-1:0]};
        dec_nxt.space          = ctrl_r.space;
        dec_nxt.width          = ctrl_r.width;
        dec_nxt.program_access = ctrl_r.program_space_flag;
        dec_nxt.supervisor     = ctrl_r.supervisor;
        dec_nxt.single_blt     = ctrl_r.block_transfer_select && is_a24_a32(ctrl_r.space) &&
                                 (ctrl_r.width != pvw_pkg::PVW_W64);
        dec_nxt.mblt_allowed   = is_a24_a32(ctrl_r.space) && (ctrl_r.width == pvw_pkg::PVW_W64);
        dec_nxt.posted         = ctrl_r.posted && !ctrl_r.pci_space_select;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decode       <= '0;
            decode_valid <= 1'b0;
        end else begin
            decode       <= dec_nxt;
            decode_valid <= pci_req;
        end
    end

    // Saturating count of claimed accesses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_count_r <= 16'h0000;
        end else if (dec_nxt.hit && hit_count_r != 16'hffff) begin
            hit_count_r <= hit_count_r + 16'h0001;
        end
    end

endmodule // pvw_window

// [rtl/pvw_pkg.sv]
// Package for the second PCI target window: register map, fields, types
package pvw_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CONTROL  = 12'h13c;
    localparam logic [11:0] OFF_BASE     = 12'h12c;
    localparam logic [11:0] OFF_LIMIT    = 12'h130;
    localparam logic [11:0] OFF_SHIFT    = 12'h134;
    localparam logic [11:0] OFF_STATUS   = 12'h140;

    // ------------------------------------------------------------
    // Control and address field positions
    // ------------------------------------------------------------
    localparam int BIT_ENABLE   = 31;
    localparam int BIT_POSTED   = 30;
    localparam int WID_HI       = 23;
    localparam int WID_LO       = 22;
    localparam int SPC_HI       = 18;
    localparam int SPC_LO       = 16;
    localparam int BIT_PROGRAM  = 14;
    localparam int BIT_SUPER    = 12;
    localparam int BIT_BLOCK    = 8;
    localparam int BIT_PCI_IO   = 0;
    localparam int ADDR_HI      = 31;
    localparam int ADDR_LO      = 16;

    // ------------------------------------------------------------
    // Reset values and no-limit code
    // ------------------------------------------------------------
    localparam logic [1:0]  RST_WIDTH  = 2'h2;
    localparam logic [2:0]  RST_SPACE  = 3'h0;
    localparam logic [15:0] RST_ADDR   = 16'h0000;
    localparam logic [15:0] LIMIT_NONE = 16'h0000;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PVW_W8  = 2'h0,
        PVW_W16 = 2'h1,
        PVW_W32 = 2'h2,
        PVW_W64 = 2'h3
    } pvw_width_e;

    typedef enum logic [2:0] {
        PVW_A16   = 3'h0,
        PVW_A24   = 3'h1,
        PVW_A32   = 3'h2,
        PVW_RSV3  = 3'h3,
        PVW_RSV4  = 3'h4,
        PVW_CRCSR = 3'h5,
        PVW_USER1 = 3'h6,
        PVW_USER2 = 3'h7
    } pvw_space_e;

    typedef enum logic [2:0] {
        PVW_ST_IDLE   = 3'b001,
        PVW_ST_ACCESS = 3'b010,
        PVW_ST_DONE   = 3'b100
    } pvw_apb_e;

    // Control register image
    typedef struct packed {
        logic       enable;
        logic       posted;
        pvw_width_e width;
        pvw_space_e space;
        logic       program_space_flag;
        logic       supervisor;
        logic       block_transfer_select;
        logic       pci_space_select;
    } pvw_ctrl_s;

    // Decision for one PCI access
    typedef struct packed {
        logic        hit;
        logic [31:0] vme_addr;
        pvw_space_e  space;
        pvw_width_e  width;
        logic        program_access;
        logic        supervisor;
        logic        single_blt;
        logic        mblt_allowed;
        logic        posted;
    } pvw_decode_s;

endpackage : pvw_pkg

// [sim/pvw_window_assertions.sv]
// Port-level checks for the second PCI window
`timescale 1ns/1ps
module pvw_window_assertions (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 pci_req,
    input wire logic [31:0]          pci_addr,
    input wire logic                 pci_io,
    input wire pvw_pkg::pvw_decode_s decode,
    input wire logic                 decode_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire sp_ok = decode.space == pvw_pkg::PVW_A24 || decode.space == pvw_pkg::PVW_A32;

    ready_wait_a: assert property (psel && !penable |-> ##2 pready) else $error("late pready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    valid_follow_a: assert property (pci_req |=> decode_valid) else $error("decode_valid missing");
    blt_gate_a: assert property (decode.single_blt |-> sp_ok && decode.width != pvw_pkg::PVW_W64)
        else $error("block transfer outside A24/A32 8-32");
    mblt_a: assert property (decode.hit |-> decode.mblt_allowed == (sp_ok && decode.width == pvw_pkg::PVW_W64))
        else $error("mblt allowance wrong");
    io_coupled_a: assert property (decode.hit && $past(pci_io) |-> !decode.posted)
        else $error("posted write in io space");
    low_pass_a: assert property (decode.hit |-> decode.vme_addr[15:0] == $past(pci_addr[15:0]))
        else $error("low address bits changed");

    hit_c: cover property (decode.hit);
    err_c: cover property (pslverr);
    mblt_c: cover property (decode.mblt_allowed);
endmodule // pvw_window_assertions

bind pvw_window pvw_window_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pci_req(pci_req), .pci_addr(pci_addr),
    .pci_io(pci_io), .decode(decode), .decode_valid(decode_valid));

// [sim/pvw_pci_master.sv]
// PCI master model driving accesses into the window
`timescale 1ns/1ps
module pvw_pci_master (
    input  wire logic        pclk,
    input  wire logic        go,
    input  wire logic [31:0] a,
    input  wire logic        io,
    output logic             pci_req = 1'b0,
    output logic [31:0]      pci_addr = 32'h0,
    output logic             pci_io = 1'b0
);
    // Idle lines show the inverse so stale values never decode by luck
    always_ff @(posedge pclk) begin
        pci_req  <= go;
        pci_addr <= go ? a : ~pci_addr;
        pci_io   <= go ? io : ~pci_io;
    end
endmodule // pvw_pci_master

// [sim/pvw_window_tb.sv]
// Self-checking bench for the second PCI window
`timescale 1ns/1ps
module pvw_window_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, io = 0, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, a = 32'h0, lf = 32'h94d1, ctl = 32'h00800000, wbase = 32'h0, wlim = 32'h0;
    logic [31:0] wshf = 32'h0, hits = 32'h0, rd;
    logic [31:0] prdata, pci_addr;
    logic        pready, pslverr, pci_req, pci_io, decode_valid;
    logic [2:0]  sptab [6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    pvw_pkg::pvw_decode_s decode;
    int n_fail = 0, comparisons = 0, cyc = 0;

    always #4 pclk = ~pclk;

    pvw_window i_pvw_window (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pci_req(pci_req),
        .pci_addr(pci_addr), .pci_io(pci_io), .decode(decode), .decode_valid(decode_valid));
    pvw_pci_master i_pvw_pci_master (.pclk(pclk), .go(go), .a(a), .io(io), .pci_req(pci_req),
        .pci_addr(pci_addr), .pci_io(pci_io));

    function automatic logic [31:0] rnd();
        lf = {lf[30:0], 1'b0} ^ (lf[31] ? 32'h80200003 : 32'h0);
        return lf;
    endfunction

    function automatic logic [42:0] expd(logic [31:0] ad, logic i);
        logic h;
        logic sp;
        h = ctl[31] && i == ctl[0] && ad[31:16] >= wbase[31:16] &&
            (wlim[31:16] == 16'h0 || ad[31:16] < wlim[31:16]);
        sp = ctl[18:16] == 3'h1 || ctl[18:16] == 3'h2;
        return h ? {h, ad[31:16] + wshf[31:16], ad[15:0], ctl[18:16], ctl[23:22], ctl[14], ctl[12],
                    ctl[8] && sp && ctl[23:22] != 2'h3, sp && ctl[23:22] == 2'h3, ctl[30] && !ctl[0]} : 43'h0;
    endfunction

    task automatic cmp(logic [42:0] got, logic [42:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(logic w, logic [11:0] ad, logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pci(logic [31:0] ad, logic i);
        logic [42:0] e;
        e = expd(ad, i);
        hits = hits + {31'h0, e[42]};
        @(posedge pclk);
        go <= 1'b1;
        a <= ad;
        io <= i;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        #1;
        cmp(decode.hit ? 43'(decode) : 43'h0, e);
        cmp(43'(decode_valid), 43'h1);
    endtask

    task automatic results();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, pvw_pkg::OFF_CONTROL, 32'h0);
        cmp(43'(rd), 43'h00800000);
        apb(1'b0, pvw_pkg::OFF_LIMIT, 32'h0);
        cmp(43'(rd), 43'h0);
        apb(1'b0, 12'h100, 32'h0);
        cmp(43'(err), 43'h1);
        pci(rnd(), 1'b0);
        $display("reset test done");
        for (int t = 0; t < 40; t++) begin
            ctl = (rnd() & 32'hc0c75101) | 32'h80000000;
            ctl[18:16] = sptab[t % 6];
            wbase = rnd() & 32'hffff0000;
            wlim = (t % 4 == 0) ? 32'h0 : wbase + (rnd() & 32'h00ff0000) + 32'h10000;
            wshf = rnd() & 32'hffff0000;
            apb(1'b1, pvw_pkg::OFF_CONTROL, ctl | 32'h0000aa00);
            apb(1'b0, pvw_pkg::OFF_CONTROL, 32'h0);
            cmp(43'(rd), 43'(ctl));
            apb(1'b1, pvw_pkg::OFF_BASE, wbase | 32'h0000beef);
            apb(1'b1, pvw_pkg::OFF_LIMIT, wlim);
            apb(1'b1, pvw_pkg::OFF_SHIFT, wshf);
            apb(1'b0, pvw_pkg::OFF_BASE, 32'h0);
            cmp(43'(rd), 43'(wbase));
            apb(1'b0, pvw_pkg::OFF_LIMIT, 32'h0);
            cmp(43'(rd), 43'(wlim));
            apb(1'b0, pvw_pkg::OFF_SHIFT, 32'h0);
            cmp(43'(rd), 43'(wshf));
            pci(wbase - 32'h1, ctl[0]);
            pci(wbase | (rnd() & 32'hffff), ctl[0]);
            pci(wlim - 32'h1, ctl[0]);
            pci(wlim, ctl[0]);
            pci(rnd(), ~ctl[0]);
            $display("window test %0d done", t);
        end
        apb(1'b0, pvw_pkg::OFF_STATUS, 32'h0);
        cmp(43'(rd), 43'(hits));
        $display("status test done");
        results();
    end
endmodule // pvw_window_tb
